/* File: design/nvsr_core.sv */
/*
  Serial target for the store, restore and tolerance read commands of a digital
  potentiometer. Assumes a board pull-up on the data line, the controller drives
  the serial clock, and the nonvolatile store itself sits outside behind a
  one-cycle request strobe.
*/
`timescale 1ns/1ns
`default_nettype none
module nvsr_core
  import nvsr_pkg::*;
#(
  parameter logic [7:0] TOL_SIGN_INT = 8'h00, // Factory value, arbitrary default
  parameter logic [7:0] TOL_FRACTION = 8'h00 // Factory value, arbitrary default
)
(
  // Clock and reset
  input wire logic clock,
  input wire logic resetn,
  // Serial pins
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // Address select straps
  input wire logic addr_select_lo,
  input wire logic addr_select_hi,
  // Nonvolatile side
  output logic [7:0] wiper_setting_reg,
  output logic store_req,
  output logic restore_req,
  input wire logic [7:0] nv_wiper_value
);
  nvsr_line_if ev();
  nvsr_state_e st_r, st_nxt;
  logic [7:0] sh_r, sh_nxt, wiper_r, wiper_nxt;
  logic [3:0] bit_r, bit_nxt;
  logic [2:0] cmd_r, cmd_nxt, pend_r, pend_nxt;
  logic [4:0] ptr_r, ptr_nxt;
  logic [6:0] my_addr_r, my_addr_nxt;
  logic [1:0] strap_cnt_r, strap_cnt_nxt;
  logic ack_r, ack_nxt, rd_r, rd_nxt;
  logic [1:0] sel_sync_r, sel_sync_nxt, sel_meta_r, sel_meta_nxt;
  logic store_r, store_nxt, restore_r, restore_nxt;

  nvsr_line_watch u_watch (
    .clock(clock),
    .resetn(resetn),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .ev(ev.watcher)
  );

  // Tolerance lookup; other locations read as zero in this block
  function automatic logic [7:0] tol_byte(input logic [4:0] loc);
    if (loc == LOC_TOL_SIGN_INT)
      tol_byte = TOL_SIGN_INT;
    else if (loc == LOC_TOL_FRACTION)
      tol_byte = TOL_FRACTION;
    else
      tol_byte = 8'h00;
  endfunction : tol_byte

  // Strap capture shortly after reset release, then frozen
  always_comb
  begin
    sel_meta_nxt = {addr_select_hi, addr_select_lo};
    sel_sync_nxt = sel_meta_r;
    strap_cnt_nxt = (strap_cnt_r == 2'h3) ? strap_cnt_r : strap_cnt_r + 2'h1;
    my_addr_nxt = my_addr_r;
    if (strap_cnt_r == 2'h2)
      my_addr_nxt = nvsr_bus_addr(sel_sync_r[1], sel_sync_r[0]);
  end

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      sel_meta_r <= 2'h0;
      sel_sync_r <= 2'h0;
      strap_cnt_r <= 2'h0;
      my_addr_r <= BUS_ADDR_00;
    end
    else
    begin
      sel_meta_r <= sel_meta_nxt;
      sel_sync_r <= sel_sync_nxt;
      strap_cnt_r <= strap_cnt_nxt;
      my_addr_r <= my_addr_nxt;
    end
  end

  // Byte engine: shifts on rising clock, changes data on falling clock
  always_comb
  begin
    st_nxt = st_r;
    sh_nxt = sh_r;
    bit_nxt = bit_r;
    cmd_nxt = cmd_r;
    ptr_nxt = ptr_r;
    ack_nxt = ack_r;
    rd_nxt = rd_r;
    pend_nxt = pend_r;
    wiper_nxt = wiper_r;
    store_nxt = 1'b0;
    restore_nxt = 1'b0;
    if (ev.stop_p)
    begin
      st_nxt = NVSR_IDLE;
      ack_nxt = 1'b0;
      if (pend_r == CMD_STORE)
        store_nxt = 1'b1;
      else if (pend_r == CMD_RESTORE)
        restore_nxt = 1'b1;
      pend_nxt = CMD_NOP;
    end
    else if (ev.start_p)
    begin
      // Repeated start drops any pending store; pointer is kept
      st_nxt = NVSR_ADDR;
      bit_nxt = 4'h0;
      ack_nxt = 1'b0;
      pend_nxt = CMD_NOP;
    end
    else if (ev.rise_p && bit_r < 4'h8)
    begin
      // Read data must not move while the clock is high, so only written bytes shift here
      if (st_r != NVSR_RDATA)
        sh_nxt = {sh_r[6:0], ev.sda_lvl};
      bit_nxt = bit_r + 4'h1;
    end
    else if (ev.rise_p && st_r == NVSR_RDATA)
    begin
      // Ninth clock: controller acknowledge decides whether to go on
      bit_nxt = 4'h9;
      if (ev.sda_lvl)
        st_nxt = NVSR_IGNORE;
      else
      begin
        ptr_nxt = ptr_r + 5'h1;
        st_nxt = NVSR_MACK;
      end
    end
    else if (ev.fall_p)
    begin
      if (bit_r == 4'h8)
      begin
        // End of a byte: decide on acknowledge
        bit_nxt = 4'h9;
        case (st_r)
          NVSR_ADDR:
          begin
            if (sh_r[7:1] == my_addr_r)
            begin
              ack_nxt = 1'b1;
              rd_nxt = sh_r[0];
            end
            else
              st_nxt = NVSR_IGNORE;
          end
          NVSR_INSTR:
          begin
            ack_nxt = 1'b1;
            cmd_nxt = sh_r[CMD_MSB:CMD_LSB];
            if (sh_r[CMD_MSB:CMD_LSB] == CMD_NV)
              ptr_nxt = sh_r[LOC_MSB:0];
            pend_nxt = sh_r[CMD_MSB:CMD_LSB];
          end
          NVSR_WDATA:
          begin
            // Tolerance locations are read-only; data is acknowledged but dropped
            ack_nxt = 1'b1;
            pend_nxt = CMD_NOP;
            if (cmd_r == CMD_WIPER)
              wiper_nxt = sh_r;
          end
          default: ack_nxt = 1'b0;
        endcase
      end
      else if (bit_r == 4'h9)
      begin
        // End of the ninth clock: release and move to the next byte
        ack_nxt = 1'b0;
        bit_nxt = 4'h0;
        case (st_r)
          NVSR_ADDR:
          begin
            st_nxt = rd_r ? NVSR_RDATA : NVSR_INSTR;
            if (rd_r)
            begin
              sh_nxt = tol_byte(ptr_r);
              bit_nxt = 4'h0;
            end
          end
          NVSR_INSTR: st_nxt = NVSR_WDATA;
          NVSR_MACK:
          begin
            st_nxt = NVSR_RDATA;
            sh_nxt = tol_byte(ptr_r);
          end
          NVSR_WDATA: st_nxt = NVSR_WDATA;
          default: st_nxt = st_r;
        endcase
      end
      else if (st_r == NVSR_RDATA && bit_r != 4'h0)
        sh_nxt = {sh_r[6:0], 1'b0};
    end
    // Restored value wins over any write in the same cycle
    if (restore_r)
      wiper_nxt = nv_wiper_value;
    if (st_r == NVSR_IDLE || st_r == NVSR_IGNORE)
      bit_nxt = (ev.start_p) ? 4'h0 : 4'ha;
    if (ev.stop_p)
      bit_nxt = 4'ha;
  end

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      st_r <= NVSR_IDLE;
      sh_r <= 8'h00;
      bit_r <= 4'ha;
      cmd_r <= CMD_NOP;
      ptr_r <= PTR_RESET;
      ack_r <= 1'b0;
      rd_r <= 1'b0;
      pend_r <= CMD_NOP;
      wiper_r <= WIPER_RESET;
      store_r <= 1'b0;
      restore_r <= 1'b0;
    end
    else
    begin
      st_r <= st_nxt;
      sh_r <= sh_nxt;
      bit_r <= bit_nxt;
      cmd_r <= cmd_nxt;
      ptr_r <= ptr_nxt;
      ack_r <= ack_nxt;
      rd_r <= rd_nxt;
      pend_r <= pend_nxt;
      wiper_r <= wiper_nxt;
      store_r <= store_nxt;
      restore_r <= restore_nxt;
    end
  end

  // Open-drain data: pull low for acknowledge or a zero read bit
  // Read bit is always the top of the shift register; held through the eighth high phase
  assign sda_out = 1'b0;
  assign sda_oe = ack_r || (st_r == NVSR_RDATA && bit_r <= 4'h8 && !sh_r[7]);
  assign wiper_setting_reg = wiper_r;
  assign store_req = store_r;
  assign restore_req = restore_r;

  // Store or restore requests only ever follow a stop
  property p_store_after_stop;
    @(posedge clock) disable iff (!resetn) store_req |-> $past(ev.stop_p);
  endproperty
  a_store_after_stop: assert property (p_store_after_stop) else $error("store without stop");
  property p_restore_after_stop;
    @(posedge clock) disable iff (!resetn) restore_req |-> $past(ev.stop_p) && !store_req;
  endproperty
  a_restore_after_stop: assert property (p_restore_after_stop) else $error("restore without stop");
  property p_store_cmd;
    @(posedge clock) disable iff (!resetn) store_req |-> $past(pend_r) == CMD_STORE;
  endproperty
  a_store_cmd: assert property (p_store_cmd) else $error("store from wrong command");
  property p_ptr_inc;
    @(posedge clock) disable iff (!resetn) (st_r == NVSR_MACK && $past(st_r) == NVSR_RDATA) |-> ptr_r == $past(ptr_r) + 5'h1;
  endproperty
  a_ptr_inc: assert property (p_ptr_inc) else $error("pointer did not advance");
  property p_tol_ro;
    @(posedge clock) disable iff (!resetn) (st_r == NVSR_WDATA && ev.fall_p && bit_r == 4'h8 && cmd_r == CMD_NV)
      |=> pend_r == CMD_NOP && wiper_r == $past(wiper_r);
  endproperty
  a_tol_ro: assert property (p_tol_ro) else $error("tolerance changed");
  property p_addr_fixed;
    @(posedge clock) disable iff (!resetn) strap_cnt_r == 2'h3 |=> $stable(my_addr_r);
  endproperty
  a_addr_fixed: assert property (p_addr_fixed) else $error("bus address moved");
  property p_instr_ptr;
    @(posedge clock) disable iff (!resetn) (st_r == NVSR_INSTR && ev.fall_p && bit_r == 4'h8 && sh_r[7:5] == CMD_NV) |=> ptr_r == $past(sh_r[4:0]);
  endproperty
  a_instr_ptr: assert property (p_instr_ptr) else $error("pointer not loaded");
  property p_nack_ends;
    @(posedge clock) disable iff (!resetn) (st_r == NVSR_RDATA && ev.rise_p && bit_r == 4'h9 && ev.sda_lvl) |=> st_r == NVSR_IGNORE && !sda_oe;
  endproperty
  a_nack_ends: assert property (p_nack_ends) else $error("read not ended by no-acknowledge");
  c_store: cover property (@(posedge clock) disable iff (!resetn) store_req);
  c_restore: cover property (@(posedge clock) disable iff (!resetn) restore_req);
  c_consec: cover property (@(posedge clock) disable iff (!resetn) st_r == NVSR_MACK && ptr_r == LOC_TOL_FRACTION);
endmodule : nvsr_core
`default_nettype wire

/* File: design/nvsr_line_watch.sv */
/*
  Synchronises the serial clock and data pins and reports edges and bus conditions.
  Assumes pins are asynchronous to clock and slower than a few clock periods.
*/
`timescale 1ns/1ns
`default_nettype none
module nvsr_line_watch
  import nvsr_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic resetn,
  // Pin levels
  input wire logic scl_in,
  input wire logic sda_in,
  // Events out
  nvsr_line_if.watcher ev
);
  logic [1:0] scl_sync_r, scl_sync_nxt, sda_sync_r, sda_sync_nxt;
  logic scl_d_r, scl_d_nxt, sda_d_r, sda_d_nxt;

  // Two-stage synchronisers, then one delayed copy for edge detect
  always_comb
  begin
    scl_sync_nxt = {scl_sync_r[0], scl_in};
    sda_sync_nxt = {sda_sync_r[0], sda_in};
    scl_d_nxt = scl_sync_r[1];
    sda_d_nxt = sda_sync_r[1];
  end

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      scl_sync_r <= 2'h3;
      sda_sync_r <= 2'h3;
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end
    else
    begin
      scl_sync_r <= scl_sync_nxt;
      sda_sync_r <= sda_sync_nxt;
      scl_d_r <= scl_d_nxt;
      sda_d_r <= sda_d_nxt;
    end
  end

  // Start and stop only count while the clock line stays high
  assign ev.start_p = scl_sync_r[1] && scl_d_r && sda_d_r && !sda_sync_r[1];
  assign ev.stop_p = scl_sync_r[1] && scl_d_r && !sda_d_r && sda_sync_r[1];
  assign ev.rise_p = scl_sync_r[1] && !scl_d_r;
  assign ev.fall_p = !scl_sync_r[1] && scl_d_r;
  assign ev.sda_lvl = sda_sync_r[1];
endmodule : nvsr_line_watch
`default_nettype wire

/* File: pkg/nvsr_line_if.sv */
/*
  Bus-line events carried from the line watcher to the protocol engine.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/1ns
`default_nettype none
interface nvsr_line_if;
  logic start_p;
  logic stop_p;
  logic rise_p;
  logic fall_p;
  logic sda_lvl;
  modport watcher (output start_p, output stop_p, output rise_p, output fall_p, output sda_lvl);
  modport engine (input start_p, input stop_p, input rise_p, input fall_p, input sda_lvl);
endinterface : nvsr_line_if
`default_nettype wire

/* File: pkg/nvsr_pkg.sv */
/*
  Constants for the nonvolatile store/restore and tolerance read block.
  Assumes a 10 MHz system clock and an I2C controller far slower than it.
*/
`default_nettype none
package nvsr_pkg;
  // Instruction byte command field values
  localparam logic [2:0] CMD_WIPER = 3'h0;
  localparam logic [2:0] CMD_NV = 3'h1;
  localparam logic [2:0] CMD_WPROT = 3'h2;
  localparam logic [2:0] CMD_NOP = 3'h4;
  localparam logic [2:0] CMD_RESTORE = 3'h5;
  localparam logic [2:0] CMD_STORE = 3'h6;
  // Tolerance locations in the nonvolatile space
  localparam logic [4:0] LOC_TOL_SIGN_INT = 5'h1e;
  localparam logic [4:0] LOC_TOL_FRACTION = 5'h1f;
  // Field positions of the instruction byte
  localparam int CMD_MSB = 7;
  localparam int CMD_LSB = 5;
  localparam int LOC_MSB = 4;
  // Four bus addresses selected by the two select pins {hi,lo}
  localparam logic [6:0] BUS_ADDR_00 = 7'h18;
  localparam logic [6:0] BUS_ADDR_01 = 7'h4c;
  localparam logic [6:0] BUS_ADDR_10 = 7'h1a;
  localparam logic [6:0] BUS_ADDR_11 = 7'h4e;
  // Reset values
  localparam logic [7:0] WIPER_RESET = 8'h80;
  localparam logic [4:0] PTR_RESET = 5'h00;
  // Receiver states
  typedef enum logic [2:0] {
    NVSR_IDLE = 3'b000,
    NVSR_ADDR = 3'b001,
    NVSR_INSTR = 3'b010,
    NVSR_WDATA = 3'b011,
    NVSR_RDATA = 3'b100,
    NVSR_MACK = 3'b101,
    NVSR_IGNORE = 3'b110
  } nvsr_state_e;
  // Bus address decode of the select pins
  function automatic logic [6:0] nvsr_bus_addr(input logic hi, input logic lo);
    case ({hi, lo})
      2'b00: nvsr_bus_addr = BUS_ADDR_00;
      2'b01: nvsr_bus_addr = BUS_ADDR_01;
      2'b10: nvsr_bus_addr = BUS_ADDR_10;
      default: nvsr_bus_addr = BUS_ADDR_11;
    endcase
  endfunction : nvsr_bus_addr
endpackage : nvsr_pkg
`default_nettype wire

/* File: test/nv_store_restore_tolerance_read_tb.sv */
/*
  Self-checking bench for the store, restore and tolerance read target.
  Assumes the controller model beside it and a pull-up on the data line.
*/
`timescale 1ns/1ns
`default_nettype none
module nv_store_restore_tolerance_read_tb
  import nvsr_pkg::*;
;
  localparam logic [7:0] TOL_SI = 8'h9c; // Factory bytes, arbitrary values
  localparam logic [7:0] TOL_FR = 8'h0f;
  logic clock, resetn, s_lo, s_hi, scl, sda_low, sda_out, sda_oe, store_req, restore_req, sda_line;
  logic [7:0] wiper, nv_val, store_cnt, restore_cnt, b0, b1, n0;
  logic ack_a, ack_i;
  logic [6:0] a;
  int err_total, num_checks, seed;
  // Open-drain resolution with pull-up
  assign sda_line = (sda_low || (sda_oe && !sda_out)) ? 1'b0 : 1'b1;
  nvsr_core #(.TOL_SIGN_INT(TOL_SI), .TOL_FRACTION(TOL_FR)) nvsr_core_inst (.clock(clock), .resetn(resetn),
    .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe), .addr_select_lo(s_lo),
    .addr_select_hi(s_hi), .wiper_setting_reg(wiper), .store_req(store_req), .restore_req(restore_req),
    .nv_wiper_value(nv_val));
  nvsr_ctrl_model nvsr_ctrl_model_inst (.clock(clock), .sda_line(sda_line), .scl(scl), .sda_low(sda_low));
  // Clock at 100 ns
  initial
  begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  // Pulse counters for the nonvolatile requests
  always @(posedge clock)
  begin
    if (store_req === 1'b1) store_cnt <= store_cnt + 8'h01;
    if (restore_req === 1'b1) restore_cnt <= restore_cnt + 8'h01;
  end
  // Bus address expected for the straps
  function automatic logic [6:0] exp_addr(input logic hi, input logic lo);
    case ({hi, lo})
      2'b00: exp_addr = 7'h18;
      2'b10: exp_addr = 7'h1a;
      2'b01: exp_addr = 7'h4c;
      default: exp_addr = 7'h4e;
    endcase
  endfunction : exp_addr
  // Tolerance byte expected at a location
  function automatic logic [7:0] tol_exp(input logic [4:0] loc);
    tol_exp = (loc == 5'h1e) ? TOL_SI : ((loc == 5'h1f) ? TOL_FR : 8'h00);
  endfunction : tol_exp
  task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk8
  task automatic chk1(input string what, input logic exp, input logic got);
    num_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("[FAIL] %s expected %b seen %b", what, exp, got);
    end
  endtask : chk1
  // Reset held 4 cycles with straps set, then settle
  task automatic do_reset(input logic hi, input logic lo);
    @(negedge clock);
    resetn = 1'b0;
    s_hi = hi;
    s_lo = lo;
    repeat (4) @(negedge clock);
    resetn = 1'b1;
    repeat (6) @(negedge clock);
  endtask : do_reset
  // Start, address with write, instruction
  task automatic send_cmd(input logic [6:0] ad, input logic [7:0] ins);
    nvsr_ctrl_model_inst.bstart();
    nvsr_ctrl_model_inst.wbyte({ad, 1'b0}, ack_a);
    ack_i = 1'b0;
    if (ack_a) nvsr_ctrl_model_inst.wbyte(ins, ack_i);
  endtask : send_cmd
  // Start, address with read, one or two bytes, stop
  task automatic rd(input int n);
    nvsr_ctrl_model_inst.bstart();
    nvsr_ctrl_model_inst.wbyte({a, 1'b1}, ack_a);
    chk1("read address ack", 1'b1, ack_a);
    nvsr_ctrl_model_inst.rbyte(n == 1, b0);
    if (n == 2) nvsr_ctrl_model_inst.rbyte(1'b1, b1);
    nvsr_ctrl_model_inst.bstop();
  endtask : rd
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : tally_and_finish
  // Watchdog well beyond the expected 6000 cycles
  initial
  begin
    repeat (60000) @(posedge clock);
    err_total++;
    tally_and_finish();
  end
  // Main sequence
  initial
  begin
    resetn = 1'b0;
    s_lo = 1'b0;
    s_hi = 1'b0;
    nv_val = 8'h00;
    store_cnt = 8'h00;
    restore_cnt = 8'h00;
    err_total = 0;
    num_checks = 0;
    seed = $urandom(13);
    do_reset(1'b0, 1'b0);
    chk8("wiper after reset", WIPER_RESET, wiper);
    // Every strap pair: foreign address ignored, own address stores after stop
    for (int k = 0; k < 4; k++)
    begin
      do_reset(k[1], k[0]);
      a = exp_addr(k[1], k[0]);
      send_cmd(a ^ 7'h02, {CMD_STORE, 5'h00});
      nvsr_ctrl_model_inst.bstop();
      chk1("foreign address ack", 1'b0, ack_a);
      n0 = store_cnt;
      send_cmd(a, {CMD_STORE, 5'h00});
      chk1("own address ack", 1'b1, ack_a);
      chk1("store instruction ack", 1'b1, ack_i);
      repeat (10) @(negedge clock);
      chk8("store count before stop", n0, store_cnt);
      nvsr_ctrl_model_inst.bstop();
      repeat (10) @(negedge clock);
      chk8("store count after stop", n0 + 8'h01, store_cnt);
    end
    // Restore from a random stored value
    nv_val = 8'($urandom);
    send_cmd(a, {CMD_RESTORE, 5'h00});
    repeat (10) @(negedge clock);
    chk8("restore count before stop", 8'h00, restore_cnt);
    nvsr_ctrl_model_inst.bstop();
    repeat (10) @(negedge clock);
    chk8("restore count after stop", 8'h01, restore_cnt);
    chk8("wiper after restore", nv_val, wiper);
    // Write attempts at the read-only locations
    for (int i = 0; i < 2; i++)
    begin
      send_cmd(a, {CMD_NV, LOC_TOL_SIGN_INT + 5'(i)});
      nvsr_ctrl_model_inst.wbyte(8'($urandom), ack_i);
      nvsr_ctrl_model_inst.bstop();
    end
    // Separate reads, fraction first so the pointer ends on the first byte
    for (int i = 0; i < 2; i++)
    begin
      send_cmd(a, {CMD_NV, LOC_TOL_FRACTION - 5'(i)});
      rd(1);
      chk8("single tolerance byte", tol_exp(LOC_TOL_FRACTION - 5'(i)), b0);
    end
    rd(1);
    chk8("direct read at pointer", TOL_SI, b0);
    send_cmd(a, {CMD_NV, LOC_TOL_SIGN_INT});
    rd(2);
    chk8("consecutive first byte", TOL_SI, b0);
    chk8("consecutive second byte", TOL_FR, b1);
    chk8("stores after reads", 8'h04, store_cnt);
    tally_and_finish();
  end
endmodule : nv_store_restore_tolerance_read_tb
`default_nettype wire

/* File: test/nvsr_ctrl_model.sv */
/*
  Bus controller model: drives the serial clock and pulls the data line low.
  Assumes the bench resolves the data line with a pull-up.
*/
`timescale 1ns/1ns
`default_nettype none
module nvsr_ctrl_model
(
  // Clock and resolved data line
  input wire logic clock,
  input wire logic sda_line,
  // Lines driven by the controller
  output logic scl,
  output logic sda_low
);
  // Bus idle: clock high, data released
  initial
  begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // Phases of 4 and 8 clocks give 400 ns and 800 ns, at or above the 400 ns minimum
  task automatic hold(input int n);
    repeat (n) @(negedge clock);
  endtask : hold
  // Start or repeated start: data falls while clock high
  task automatic bstart();
    sda_low = 1'b0;
    hold(4);
    scl = 1'b1;
    hold(8);
    sda_low = 1'b1;
    hold(8);
    scl = 1'b0;
    hold(4);
  endtask : bstart
  // Stop: data rises while clock high
  task automatic bstop();
    sda_low = 1'b1;
    hold(4);
    scl = 1'b1;
    hold(8);
    sda_low = 1'b0;
    hold(8);
  endtask : bstop
  // One bit driven by the controller
  task automatic wbit(input logic b);
    sda_low = !b;
    hold(4);
    scl = 1'b1;
    hold(8);
    scl = 1'b0;
    hold(4);
  endtask : wbit
  // One bit driven by the target, sampled late in the high phase
  task automatic rbit(output logic b);
    sda_low = 1'b0;
    hold(4);
    scl = 1'b1;
    hold(7);
    b = sda_line;
    hold(1);
    scl = 0;
    hold(4);
  endtask : rbit
  // Byte out, most significant bit first, then the target acknowledge
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic nb;
    for (int i = 7; i >= 0; i--) wbit(d[i]);
    rbit(nb);
    ack = !nb;
  endtask : wbyte
  // Byte in; acknowledge unless last, no-acknowledge on the last
  task automatic rbyte(input logic last, output logic [7:0] d);
    for (int i = 7; i >= 0; i--) rbit(d[i]);
    wbit(last);
  endtask : rbyte
endmodule : nvsr_ctrl_model
`default_nettype wire
